// file: rlva_pkg.sv
`default_nettype none
package rlva_pkg;
  // ----------------------------------------------------------------------
  // timing and thresholds
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned T1_ZERO_LIMIT  = 100;
  localparam int unsigned E1_ZERO_LIMIT  = 255;
  localparam int unsigned T1_WINDOW      = 100;
  localparam int unsigned E1_WINDOW      = 255;
  localparam int unsigned STRICT_RUN_MAX = 15;
  localparam int unsigned LOOSE_RUN_MAX  = 99;
  // 12.5 percent expressed as ones per eight positions
  localparam int unsigned DENSITY_DIV    = 8;
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_MIN_US10  = 10;   // 1.0 ms in 100 us units
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_MAX_US10  = 26;   // 2.6 ms in 100 us units
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_UI_MIN    = 10;
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_UI_MAX    = 255;
  // cycles for 1.0 ms, exact at 40 MHz; well inside 2.6 ms
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_MS_CYCLES =
    (CLK_HZ / 10000) * ANALOG_SIGNAL_LOSS_FLAG_MIN_US10;
  localparam int unsigned ANALOG_SIGNAL_LOSS_FLAG_MS_MAX_CYC =
    (CLK_HZ / 10000) * ANALOG_SIGNAL_LOSS_FLAG_MAX_US10;
  // unit-interval count chosen inside the 10..255 band
  localparam logic [7:0]  ANALOG_SIGNAL_LOSS_FLAG_UI_COUNT  = 8'h20;
  localparam logic [7:0]  CNT_W          = 8'h09;
endpackage : rlva_pkg
`default_nettype wire

// file: rlva_viol_if.sv
`default_nettype none
interface rlva_viol_if;
  logic pos;
  logic neg;
  logic strobe;
  logic code_en;
  logic viol;
  modport src (output pos, output neg, output strobe, output code_en,
               input viol);
  modport det (input pos, input neg, input strobe, input code_en,
               output viol);
endinterface : rlva_viol_if
`default_nettype wire

// file: rlva_viol_det.sv
`default_nettype none
module rlva_viol_det
(
  input  wire logic  mclk_i,
  input  wire logic  resetn_i,
  rlva_viol_if.det   vif
);
  import rlva_pkg::*;
  // ----------------------------------------------------------------------
  // polarity and zero-run tracking
  // ----------------------------------------------------------------------
  logic       last_pol_reg;
  logic       last_pol_next;
  logic       seen_reg;
  logic       seen_next;
  logic [2:0] zrun_reg;
  logic [2:0] zrun_next;
  logic       bipolar_violation_flag;
  logic       subst_ok;

  always_comb
  begin
    last_pol_next = last_pol_reg;
    seen_next     = seen_reg;
    zrun_next     = zrun_reg;
    bipolar_violation_flag           = 1'b0;
    subst_ok      = 1'b0;
    if (vif.strobe)
    begin
      if (vif.pos || vif.neg)
      begin
        bipolar_violation_flag = (vif.pos && vif.neg) ||
              (seen_reg && (vif.pos == last_pol_reg));
        // substitution patterns violate after three zeros or more
        subst_ok = (zrun_reg >= 3'h3);
        last_pol_next = vif.pos;
        seen_next     = 1'b1;
        zrun_next     = 3'h0;
      end
      else if (zrun_reg != 3'h7)
      begin
        zrun_next = zrun_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      last_pol_reg <= 1'b0;
      seen_reg     <= 1'b0;
      zrun_reg     <= 3'h0;
    end
    else
    begin
      last_pol_reg <= last_pol_next;
      seen_reg     <= seen_next;
      zrun_reg     <= zrun_next;
    end
  end

  // all violations, or only those not forming substitution codes
  assign vif.viol = vif.code_en ? (bipolar_violation_flag && !subst_ok) : bipolar_violation_flag;
endmodule : rlva_viol_det
`default_nettype wire

// file: rlva_alarms.sv
// Summary of operation
// - violation output only in single-rail; dual-rail carries negative data.
// - coding off: flag every bipolar violation on shared output.
// - coding on: flag plain violations, not substitution code violations.
// - T1: digital loss set after 100 consecutive zeros.
// - T1: clear needs 12.5% ones, zero run of at most 15 or 99.
// - E1: set after 255 zeros, clear at 12.5% ones density.
// - timer select 0: analog loss declared between 1.0 and 2.6 ms.
// - timer select 1: analog loss declared between 10 and 255 UI.
// - density window is 100 positions T1, 255 positions E1.
// - status latched until read; interrupt on rise unless masked.
// - strict select adds 15-zero limit in T1; no effect in E1.
`default_nettype none
module rlva_alarms
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic rx_pos_i,
  input  wire logic rx_neg_i,
  input  wire logic rx_strobe_i,
  input  wire logic analog_low_i,
  input  wire logic e1_mode_i,
  input  wire logic dual_rail_i,
  input  wire logic code_en_i,
  input  wire logic analog_loss_timer_select_i,
  input  wire logic digital_loss_standard_select_i,
  input  wire logic status_read_i,
  input  wire logic mask_analog_i,
  input  wire logic mask_digital_i,
  input  wire logic mask_channel_i,
  input  wire logic mask_global_i,
  output logic      rx_neg_or_violation_out_o,
  output logic      digital_signal_loss_flag_o,
  output logic      analog_signal_loss_flag_o,
  output logic      digital_loss_status_o,
  output logic      analog_loss_status_o,
  output logic      irq_o
);
  import rlva_pkg::*;
  default clocking chk_clk @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sy1_reg;
  logic [3:0] sy2_reg;
  logic       stb_d_reg;
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      sy1_reg   <= 4'h0;
      sy2_reg   <= 4'h0;
      stb_d_reg <= 1'b0;
    end
    else
    begin
      sy1_reg   <= {analog_low_i, rx_strobe_i, rx_neg_i, rx_pos_i};
      sy2_reg   <= sy1_reg;
      stb_d_reg <= sy2_reg[2];
    end
  end
  logic pos_s;
  logic neg_s;
  logic bit_tick;
  logic alow_s;
  assign pos_s    = sy2_reg[0];
  assign neg_s    = sy2_reg[1];
  assign bit_tick = sy2_reg[2] && !stb_d_reg;
  assign alow_s   = sy2_reg[3];
  logic one_s;
  assign one_s = pos_s || neg_s;

  // ----------------------------------------------------------------------
  // violation detector
  // ----------------------------------------------------------------------
  rlva_viol_if vif ();
  assign vif.pos     = pos_s;
  assign vif.neg     = neg_s;
  assign vif.strobe  = bit_tick;
  assign vif.code_en = code_en_i;
  rlva_viol_det u_det (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .vif      (vif)
  );

  logic rnv_reg;
  logic rnv_next;
  always_comb
  begin
    rnv_next = rnv_reg;
    if (bit_tick)
      rnv_next = dual_rail_i ? neg_s : vif.viol;
  end

  // ----------------------------------------------------------------------
  // digital loss detector
  // ----------------------------------------------------------------------
  logic [8:0] zcnt_reg;
  logic [8:0] zcnt_next;
  logic [8:0] wpos_reg;
  logic [8:0] wpos_next;
  logic [8:0] wones_reg;
  logic [8:0] wones_next;
  logic       wmaxz_ok_reg;
  logic       wmaxz_ok_next;
  logic       digital_signal_loss_flag_reg;
  logic       digital_signal_loss_flag_next;
  logic [8:0] zlim;
  logic [8:0] wlen;
  logic [8:0] runmax;
  logic [8:0] wones_now;
  logic       run_ok;
  logic       dens_ok;

  always_comb
  begin
    zlim   = e1_mode_i ? 9'(E1_ZERO_LIMIT) : 9'(T1_ZERO_LIMIT);
    wlen   = e1_mode_i ? 9'(E1_WINDOW) : 9'(T1_WINDOW);
    runmax = (!e1_mode_i && digital_loss_standard_select_i) ?
             9'(STRICT_RUN_MAX) : 9'(LOOSE_RUN_MAX);
    zcnt_next     = zcnt_reg;
    wpos_next     = wpos_reg;
    wones_next    = wones_reg;
    wmaxz_ok_next = wmaxz_ok_reg;
    digital_signal_loss_flag_next     = digital_signal_loss_flag_reg;
    wones_now     = wones_reg + {8'h00, one_s};
    dens_ok       = (12'(DENSITY_DIV) * {3'h0, wones_now}) >=
                    {3'h0, wlen};
    run_ok        = wmaxz_ok_reg && (zcnt_reg < runmax);
    if (bit_tick)
    begin
      zcnt_next = one_s ? 9'h000 :
                  (zcnt_reg == 9'h1ff ? zcnt_reg : zcnt_reg + 9'h001);
      if (!one_s && (zcnt_reg + 9'h001 >= zlim))
        digital_signal_loss_flag_next = 1'b1;
      if (!one_s && (zcnt_reg + 9'h001 > runmax))
        wmaxz_ok_next = 1'b0;
      if (wpos_reg + 9'h001 >= wlen)
      begin
        // window ends: clear on density, plus run limit in T1
        if (digital_signal_loss_flag_reg && dens_ok &&
            (e1_mode_i || (run_ok && !((!one_s) &&
             (zcnt_reg + 9'h001 > runmax)))))
          digital_signal_loss_flag_next = 1'b0;
        wpos_next     = 9'h000;
        wones_next    = 9'h000;
        wmaxz_ok_next = 1'b1;
      end
      else
      begin
        wpos_next  = wpos_reg + 9'h001;
        wones_next = wones_now;
      end
    end
  end

  // ----------------------------------------------------------------------
  // analog loss timer
  // ----------------------------------------------------------------------
  logic [16:0] atim_reg;
  logic [16:0] atim_next;
  logic        analog_signal_loss_flag_reg;
  logic        analog_signal_loss_flag_next;
  always_comb
  begin
    atim_next = atim_reg;
    analog_signal_loss_flag_next = analog_signal_loss_flag_reg;
    if (!alow_s)
    begin
      atim_next = 17'h00000;
      analog_signal_loss_flag_next = 1'b0;
    end
    else if (analog_loss_timer_select_i)
    begin
      if (bit_tick)
        atim_next = atim_reg + 17'h00001;
      if (atim_reg >= 17'(ANALOG_SIGNAL_LOSS_FLAG_UI_COUNT))
        analog_signal_loss_flag_next = 1'b1;
    end
    else
    begin
      atim_next = (atim_reg == 17'h1ffff) ? atim_reg : atim_reg + 17'h00001;
      if (atim_reg >= 17'(ANALOG_SIGNAL_LOSS_FLAG_MS_CYCLES))
        analog_signal_loss_flag_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // latched status and interrupt
  // ----------------------------------------------------------------------
  logic dst_reg;
  logic dst_next;
  logic ast_reg;
  logic ast_next;
  logic irq_reg;
  logic irq_next;
  logic d_rise;
  logic a_rise;
  always_comb
  begin
    d_rise   = digital_signal_loss_flag_next && !digital_signal_loss_flag_reg;
    a_rise   = analog_signal_loss_flag_next && !analog_signal_loss_flag_reg;
    dst_next = (status_read_i ? 1'b0 : dst_reg) | d_rise;
    ast_next = (status_read_i ? 1'b0 : ast_reg) | a_rise;
    irq_next = (status_read_i ? 1'b0 : irq_reg) |
               ((!mask_global_i && !mask_channel_i) &&
                ((d_rise && !mask_digital_i) ||
                 (a_rise && !mask_analog_i)));
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      rnv_reg      <= 1'b0;
      zcnt_reg     <= 9'h000;
      wpos_reg     <= 9'h000;
      wones_reg    <= 9'h000;
      wmaxz_ok_reg <= 1'b1;
      digital_signal_loss_flag_reg     <= 1'b0;
      atim_reg     <= 17'h00000;
      analog_signal_loss_flag_reg     <= 1'b0;
      dst_reg      <= 1'b0;
      ast_reg      <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      rnv_reg      <= rnv_next;
      zcnt_reg     <= zcnt_next;
      wpos_reg     <= wpos_next;
      wones_reg    <= wones_next;
      wmaxz_ok_reg <= wmaxz_ok_next;
      digital_signal_loss_flag_reg     <= digital_signal_loss_flag_next;
      atim_reg     <= atim_next;
      analog_signal_loss_flag_reg     <= analog_signal_loss_flag_next;
      dst_reg      <= dst_next;
      ast_reg      <= ast_next;
      irq_reg      <= irq_next;
    end
  end

  assign rx_neg_or_violation_out_o  = rnv_reg;
  assign digital_signal_loss_flag_o = digital_signal_loss_flag_reg;
  assign analog_signal_loss_flag_o  = analog_signal_loss_flag_reg;
  assign digital_loss_status_o      = dst_reg;
  assign analog_loss_status_o       = ast_reg;
  assign irq_o                      = irq_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_t1_last_zero;
    bit_tick && !one_s && !e1_mode_i && (zcnt_reg == 9'd99);
  endsequence
  sequence s_e1_last_zero;
    bit_tick && !one_s && e1_mode_i && (zcnt_reg == 9'd254);
  endsequence
  chk_dual_rail_neg: assert property (
    bit_tick && dual_rail_i |=> rnv_reg == $past(neg_s))
    else $error("dual rail output not negative data");
  chk_t1_zero_set: assert property (s_t1_last_zero |=> digital_signal_loss_flag_reg)
    else $error("t1 loss not set at 100 zeros");
  chk_e1_zero_set: assert property (s_e1_last_zero |=> digital_signal_loss_flag_reg)
    else $error("e1 loss not set at 255 zeros");
  chk_no_early_set: assert property (
    $rose(digital_signal_loss_flag_reg) |-> $past(zcnt_reg) + 9'd1 >= $past(zlim))
    else $error("loss set early");
  chk_clear_density: assert property (
    $fell(digital_signal_loss_flag_reg) |-> $past(dens_ok))
    else $error("loss cleared without density");
  chk_analog_ms: assert property (
    $rose(analog_signal_loss_flag_reg) && !analog_loss_timer_select_i |->
    $past(atim_reg) >= 17'(ANALOG_SIGNAL_LOSS_FLAG_MS_CYCLES))
    else $error("analog loss early");
  chk_status_hold: assert property (
    dst_reg && !status_read_i |=> dst_reg)
    else $error("status dropped without read");
  chk_irq_masked: assert property (
    mask_global_i && $stable(mask_global_i) && !irq_reg |=> !irq_reg)
    else $error("interrupt despite global mask");
endmodule : rlva_alarms
`default_nettype wire

// file: rlva_line_model.sv
`default_nettype none
module rlva_line_model
(
  input  wire logic mclk_i,
  output logic      pos_o,
  output logic      neg_o,
  output logic      strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mark_neg;
  initial
  begin
    pos_o = 1'b0;
    neg_o = 1'b0;
    strobe_o = 1'b0;
    mark_neg = 1'b0;
  end
  // ----------------------------------------------------------------
  // one recovered bit: data set up, strobe high 5, low 4
  // ----------------------------------------------------------------
  task automatic send_bit(input logic p, input logic n);
    pos_o = p;
    neg_o = n;
    @(posedge mclk_i);
    #2;
    strobe_o = 1'b1;
    repeat (5) @(posedge mclk_i);
    #2;
    strobe_o = 1'b0;
    // rails no longer valid once strobe drops
    pos_o = ~p;
    neg_o = ~n;
    repeat (4) @(posedge mclk_i);
    #2;
  endtask : send_bit
  // alternate mark inversion, no violations
  task automatic send_ami(input logic b);
    send_bit(b & ~mark_neg, b & mark_neg);
    mark_neg = mark_neg ^ b;
  endtask : send_ami
endmodule : rlva_line_model
`default_nettype wire

// file: tb_rlva_alarms.sv
`default_nettype none
module tb_rlva_alarms;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i, a_low, e1, dual, code, tsel, ssel, rd;
  logic m_a, m_d, m_c, m_g;
  logic pos, neg, strb, viol, d_flag, a_flag, d_stat, a_stat, irq;
  int   fail_count = 0;
  int   n_tests = 0;
  always #12.5 mclk_i = ~mclk_i;
  rlva_line_model u_rlva_line_model (.mclk_i(mclk_i), .pos_o(pos),
    .neg_o(neg), .strobe_o(strb));
  rlva_alarms u_rlva_alarms (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .rx_pos_i(pos), .rx_neg_i(neg), .rx_strobe_i(strb),
    .analog_low_i(a_low), .e1_mode_i(e1), .dual_rail_i(dual),
    .code_en_i(code), .analog_loss_timer_select_i(tsel),
    .digital_loss_standard_select_i(ssel), .status_read_i(rd),
    .mask_analog_i(m_a), .mask_digital_i(m_d), .mask_channel_i(m_c),
    .mask_global_i(m_g), .rx_neg_or_violation_out_o(viol),
    .digital_signal_loss_flag_o(d_flag),
    .analog_signal_loss_flag_o(a_flag), .digital_loss_status_o(d_stat),
    .analog_loss_status_o(a_stat), .irq_o(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : tick
  task automatic check(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic send(input logic p, input logic n);
    u_rlva_line_model.send_bit(p, n);
  endtask : send
  task automatic pattern(input int ones, input int zeros, input int groups);
    repeat (groups)
    begin
      repeat (ones) u_rlva_line_model.send_ami(1'b1);
      repeat (zeros) u_rlva_line_model.send_ami(1'b0);
    end
  endtask : pattern
  task automatic read_status();
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
  endtask : read_status
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_violation();
    send(1'b1, 1'b0);
    send(1'b0, 1'b1);
    check("viol alternate", 1'b0, viol);
    send(1'b0, 1'b1);
    check("viol same", 1'b1, viol);
    for (int c = 0; c < 2; c++)
    begin
      code = c[0];
      send(1'b1, 1'b0);
      repeat (3) send(1'b0, 1'b0);
      send(1'b1, 1'b0);
      check("viol subst", ~c[0], viol);
    end
    send(1'b1, 1'b0);
    check("viol code plain", 1'b1, viol);
    code = 1'b0;
    dual = 1'b1;
    send(1'b0, 1'b1);
    check("dual neg", 1'b1, viol);
    send(1'b1, 1'b0);
    send(1'b1, 1'b0);
    check("dual pos", 1'b0, viol);
    dual = 1'b0;
  endtask : test_violation
  task automatic test_t1_loss();
    pattern(1, 0, 8);
    pattern(0, 99, 1);
    check("t1 99 zeros", 1'b0, d_flag);
    pattern(0, 1, 1);
    check("t1 100 zeros", 1'b1, d_flag);
    check("t1 status", 1'b1, d_stat);
    check("t1 irq", 1'b1, irq);
    pattern(1, 11, 20);
    check("t1 sparse", 1'b1, d_flag);
    ssel = 1'b1;
    pattern(4, 16, 12);
    check("t1 strict run", 1'b1, d_flag);
    ssel = 1'b0;
    pattern(4, 16, 12);
    check("t1 recover", 1'b0, d_flag);
    read_status();
    check("t1 read", 1'b0, d_stat);
    check("t1 irq read", 1'b0, irq);
  endtask : test_t1_loss
  task automatic test_e1_loss();
    e1 = 1'b1;
    m_d = 1'b1;
    ssel = 1'b1;
    pattern(1, 254, 1);
    check("e1 254 zeros", 1'b0, d_flag);
    pattern(0, 1, 1);
    check("e1 255 zeros", 1'b1, d_flag);
    check("e1 status", 1'b1, d_stat);
    check("e1 masked irq", 1'b0, irq);
    pattern(4, 16, 26);
    check("e1 recover", 1'b0, d_flag);
    read_status();
    check("e1 read", 1'b0, d_stat);
    m_d = 1'b0;
    ssel = 1'b0;
  endtask : test_e1_loss
  task automatic test_analog_ui();
    tsel = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      {m_g, m_c, m_a} = 3'b001 << m;
      a_low = 1'b1;
      pattern(1, 0, 9);
      check("ui early", 1'b0, a_flag);
      for (int k = 0; k < 246 && a_flag !== 1'b1; k++) pattern(1, 0, 1);
      check("ui late", 1'b1, a_flag);
      check("ui status", 1'b1, a_stat);
      check("ui irq", logic'(m == 3), irq);
      a_low = 1'b0;
      tick(4);
      read_status();
      check("ui read", 1'b0, a_stat);
    end
  endtask : test_analog_ui
  task automatic test_analog_ms();
    tsel = 1'b0;
    a_low = 1'b1;
    tick(39999);
    check("ms early", 1'b0, a_flag);
    for (int k = 0; k < 64000 && a_flag !== 1'b1; k++) tick(1);
    check("ms late", 1'b1, a_flag);
    a_low = 1'b0;
    tick(4);
    read_status();
  endtask : test_analog_ms
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    {resetn_i, a_low, e1, dual, code, tsel, ssel, rd} = 8'h00;
    {m_a, m_d, m_c, m_g} = 4'h0;
    tick(8);
    resetn_i = 1'b1;
    tick(2);
    check("reset irq", 1'b0, irq);
    test_violation();
    test_t1_loss();
    test_e1_loss();
    test_analog_ui();
    test_analog_ms();
    stop_test();
  end
  initial
  begin
    #(90000 * 25);
    fail_count++;
    stop_test();
  end
endmodule : tb_rlva_alarms
`default_nettype wire
